// *** rtl/ptm_pkg.sv ***
// shared constants, register map and types of the periodic timer
package ptm_pkg;

    localparam int unsigned PTM_DW = 16;
    localparam int unsigned PTM_AW = 3;
    localparam int unsigned PTM_CW = 10;

    // register offsets, one word each
    localparam logic [PTM_AW-1:0] ADDR_RUN    = 3'h0;
    localparam logic [PTM_AW-1:0] ADDR_CTRL   = 3'h1;
    localparam logic [PTM_AW-1:0] ADDR_COUNT  = 3'h2;
    localparam logic [PTM_AW-1:0] ADDR_CMPA   = 3'h3;
    localparam logic [PTM_AW-1:0] ADDR_CMPP   = 3'h4;
    localparam logic [PTM_AW-1:0] ADDR_STATUS = 3'h5;

    // field positions in the run and status words, and the control word width
    localparam int unsigned RUN_BIT_POS    = 0;
    localparam int unsigned FLAG_A_POS     = 0;
    localparam int unsigned FLAG_P_POS     = 1;
    localparam int unsigned CTRL_WIDTH     = 8;

    typedef enum logic [1:0] {
        PTM_MODE_CMP = 2'b00,
        PTM_MODE_CAP = 2'b01,
        PTM_MODE_PWM = 2'b10,
        PTM_MODE_TMR = 2'b11
    } ptm_mode_t;

    // control word layout, msb first: bits 7..0
    typedef struct packed {
        ptm_mode_t  mode_select;
        logic [1:0] io_ctrl;
        logic       out_init;
        logic       out_invert;
        logic       capture_source_select;
        logic       clear_sel;
    } ptm_ctrl_t;

    // the two compare values travel together
    typedef struct packed {
        logic [PTM_CW-1:0] compare_a_value;
        logic [PTM_CW-1:0] compare_p_value;
    } ptm_cmp_t;

    localparam ptm_ctrl_t         RST_CTRL  = ptm_ctrl_t'(8'h00);
    localparam logic [PTM_CW-1:0] RST_VALUE = 10'h000;
    localparam logic [PTM_CW-1:0] CNT_MAX   = 10'h3ff;
    localparam logic [1:0]        IO_LOW    = 2'h1;
    localparam logic [1:0]        IO_HIGH   = 2'h2;
    localparam logic [1:0]        IO_TOGGLE = 2'h3;
    localparam logic [1:0]        IO_FORCE_LO = 2'h0;
    localparam logic [1:0]        IO_FORCE_HI = 2'h1;
    localparam logic [1:0]        CAP_RISE  = 2'h0;
    localparam logic [1:0]        CAP_FALL  = 2'h1;
    localparam logic [1:0]        CAP_BOTH  = 2'h2;

endpackage

// *** rtl/ptm_timer.sv ***
// periodic timer: compare, timer, pwm, single pulse and capture modes
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns

module ptm_timer (
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire logic [ptm_pkg::PTM_AW-1:0] reg_addr,
    input  wire logic [ptm_pkg::PTM_DW-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [ptm_pkg::PTM_DW-1:0] reg_rdata,
    input  wire logic                       timer_tick,
    input  wire logic                       capture_input_pin,
    input  wire logic                       external_clock_pin,
    output logic                            timer_out,
    output logic                            timer_out_oe,
    output logic                            match_a_flag,
    output logic                            match_p_flag
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    ptm_pkg::ptm_ctrl_t             ctrl;
    ptm_pkg::ptm_cmp_t              cmp;
    logic                           run_bit;
    logic                           run_prev;
    logic [ptm_pkg::PTM_CW-1:0]     cnt;
    logic                           out_state;
    logic                           cap_prev;
    logic                           ext_prev;

    logic                           run_rise;
    logic                           step;
    logic                           a_eq;
    logic                           p_eq;
    logic                           single;
    logic                           cnt_clr;
    logic                           a_ev;
    logic                           p_ev;
    logic                           cap_src;
    logic                           cap_ev;
    logic                           cap_last;
    logic                           ext_rise;
    logic                           wave;
    logic                           next_pin;
    logic                           next_oe;
    logic                           next_out_state;
    logic [ptm_pkg::PTM_CW-1:0]     next_cnt;
    logic [ptm_pkg::PTM_DW-1:0]     next_rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // events

    // matches are seen one count early so the counter lands on the value or clears
    always_comb begin
        run_rise = run_bit & ~run_prev;
        step     = run_bit & timer_tick;
        a_eq     = (cnt == cmp.compare_a_value - 10'h001);
        // zero P value wraps to 3ff, giving 1024 counts
        p_eq     = (cnt == cmp.compare_p_value - 10'h001);
        single   = (ctrl.mode_select == ptm_pkg::PTM_MODE_PWM) &&
                   (ctrl.io_ctrl == 2'h3);
        cap_src  = ctrl.capture_source_select ? external_clock_pin
                                              : capture_input_pin;
        // each pin keeps its own history, so switching the source makes no false edge
        cap_last = ctrl.capture_source_select ? ext_prev : cap_prev;
        ext_rise = external_clock_pin & ~ext_prev;
        cnt_clr  = 1'b0;
        a_ev     = 1'b0;
        p_ev     = 1'b0;
        cap_ev   = 1'b0;
        case (ctrl.mode_select)
            ptm_pkg::PTM_MODE_CMP, ptm_pkg::PTM_MODE_TMR: begin
                a_ev = step & a_eq & (cmp.compare_a_value != 10'h000);
                if (ctrl.clear_sel) begin
                    cnt_clr = a_eq;
                end else begin
                    cnt_clr = p_eq;
                    p_ev    = step & p_eq;
                end
            end
            ptm_pkg::PTM_MODE_PWM: begin
                a_ev = step & a_eq & (cmp.compare_a_value != 10'h000);
                // a restart zeroes the counter, so a stale count must not end the pulse
                if (single && run_rise) begin
                    a_ev = 1'b0;
                end
                if (!single) begin
                    cnt_clr = p_eq;
                    p_ev    = step & p_eq;
                end
            end
            ptm_pkg::PTM_MODE_CAP: begin
                cnt_clr = p_eq;
                p_ev    = step & p_eq;
                case (ctrl.io_ctrl)
                    ptm_pkg::CAP_RISE: cap_ev = cap_src & ~cap_last;
                    ptm_pkg::CAP_FALL: cap_ev = ~cap_src & cap_last;
                    ptm_pkg::CAP_BOTH: cap_ev = cap_src ^ cap_last;
                    default:           cap_ev = 1'b0;
                endcase
                a_ev = cap_ev;
            end
            default: begin
                cnt_clr = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counter

    always_comb begin
        next_cnt = cnt;
        if (single && run_rise) begin
            next_cnt = ptm_pkg::RST_VALUE;
        end else if (step) begin
            next_cnt = cnt_clr ? ptm_pkg::RST_VALUE : cnt + 10'h001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt      <= ptm_pkg::RST_VALUE;
            run_prev <= 1'b0;
            cap_prev <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            run_prev <= run_bit;
            cap_prev <= capture_input_pin;
            ext_prev <= external_clock_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= ptm_pkg::RST_CTRL;
            cmp  <= '0;
        end else begin
            if (reg_wr && reg_addr == ptm_pkg::ADDR_CTRL) begin
                ctrl <= ptm_pkg::ptm_ctrl_t'(reg_wdata[ptm_pkg::CTRL_WIDTH-1:0]);
            end
            if (reg_wr && reg_addr == ptm_pkg::ADDR_CMPP) begin
                cmp.compare_p_value <= reg_wdata[ptm_pkg::PTM_CW-1:0];
            end
            // a capture in the same cycle beats a software write
            if (cap_ev) begin
                cmp.compare_a_value <= cnt;
            end else if (reg_wr && reg_addr == ptm_pkg::ADDR_CMPA) begin
                cmp.compare_a_value <= reg_wdata[ptm_pkg::PTM_CW-1:0];
            end
        end
    end

    // software leaves io_ctrl at 11 while single pulse is in use
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_bit <= 1'b0;
        end else begin
            if (single && a_ev) begin
                run_bit <= 1'b0;
            end
            if (reg_wr && reg_addr == ptm_pkg::ADDR_RUN) begin
                run_bit <= reg_wdata[ptm_pkg::RUN_BIT_POS];
            end
            if (single && ext_rise) begin
                run_bit <= 1'b1;
            end
        end
    end

    // flags: write one to clear, a new event in the same cycle wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == ptm_pkg::ADDR_STATUS) begin
                if (reg_wdata[ptm_pkg::FLAG_A_POS]) begin
                    match_a_flag <= 1'b0;
                end
                if (reg_wdata[ptm_pkg::FLAG_P_POS]) begin
                    match_p_flag <= 1'b0;
                end
            end
            if (a_ev) begin
                match_a_flag <= 1'b1;
            end
            if (p_ev) begin
                match_p_flag <= 1'b1;
            end
        end
    end

    always_comb begin
        next_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                ptm_pkg::ADDR_RUN:    next_rdata[ptm_pkg::RUN_BIT_POS] = run_bit;
                ptm_pkg::ADDR_CTRL:   next_rdata[ptm_pkg::CTRL_WIDTH-1:0] = ctrl;
                ptm_pkg::ADDR_COUNT:  next_rdata[ptm_pkg::PTM_CW-1:0] = cnt;
                ptm_pkg::ADDR_CMPA:   next_rdata[ptm_pkg::PTM_CW-1:0] = cmp.compare_a_value;
                ptm_pkg::ADDR_CMPP:   next_rdata[ptm_pkg::PTM_CW-1:0] = cmp.compare_p_value;
                ptm_pkg::ADDR_STATUS: begin
                    next_rdata[ptm_pkg::FLAG_A_POS] = match_a_flag;
                    next_rdata[ptm_pkg::FLAG_P_POS] = match_p_flag;
                end
                default:              next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output pin

    always_comb begin
        next_out_state = out_state;
        if (run_rise) begin
            next_out_state = ctrl.out_init;
        end else if (ctrl.mode_select == ptm_pkg::PTM_MODE_CMP && a_ev) begin
            case (ctrl.io_ctrl)
                ptm_pkg::IO_LOW:    next_out_state = 1'b0;
                ptm_pkg::IO_HIGH:   next_out_state = 1'b1;
                ptm_pkg::IO_TOGGLE: next_out_state = ~out_state;
                default:            next_out_state = out_state;
            endcase
        end
    end

    // pwm counting runs on whatever io_ctrl forces onto the pin
    always_comb begin
        wave     = (cnt < cmp.compare_a_value) ? ctrl.out_init : ~ctrl.out_init;
        next_pin = 1'b0;
        next_oe  = 1'b0;
        case (ctrl.mode_select)
            ptm_pkg::PTM_MODE_CMP: begin
                next_pin = out_state ^ ctrl.out_invert;
                next_oe  = 1'b1;
            end
            ptm_pkg::PTM_MODE_PWM: begin
                next_oe = 1'b1;
                case (ctrl.io_ctrl)
                    ptm_pkg::IO_FORCE_LO: next_pin = ctrl.out_invert;
                    ptm_pkg::IO_FORCE_HI: next_pin = ~ctrl.out_invert;
                    ptm_pkg::IO_HIGH:     next_pin = wave ^ ctrl.out_invert;
                    default: begin
                        next_pin = (run_bit ? ctrl.out_init : ~ctrl.out_init)
                                   ^ ctrl.out_invert;
                    end
                endcase
            end
            default: begin
                next_pin = 1'b0;
                next_oe  = 1'b0;
            end
        endcase
    end

    // the pin lags its cause by one clock so it comes from a flip-flop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_state    <= 1'b0;
            timer_out    <= 1'b0;
            timer_out_oe <= 1'b0;
        end else begin
            out_state    <= next_out_state;
            timer_out    <= next_pin;
            timer_out_oe <= next_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_NO_PIN_OE: assert property (
        (ctrl.mode_select == ptm_pkg::PTM_MODE_TMR ||
         ctrl.mode_select == ptm_pkg::PTM_MODE_CAP) |=> !timer_out_oe)
        else $error("pin driven in timer or capture mode");

    AST_P_CLEARS: assert property (
        (ctrl.mode_select == ptm_pkg::PTM_MODE_CMP && !ctrl.clear_sel && step && p_eq)
        |=> (cnt == 10'h000) && match_p_flag)
        else $error("P match did not clear counter and raise flag");

    AST_NO_P_FLAG: assert property (
        $rose(match_p_flag) |-> !($past(ctrl.clear_sel) &&
         $past(ctrl.mode_select) == ptm_pkg::PTM_MODE_CMP))
        else $error("P flag raised with clear_sel high");

    AST_ZERO_A: assert property (
        $rose(match_a_flag) |-> ($past(cmp.compare_a_value) != 10'h000 ||
         $past(ctrl.mode_select) == ptm_pkg::PTM_MODE_CAP))
        else $error("A flag raised with zero A value");

    AST_PIN_HOLD: assert property (
        (ctrl.mode_select == ptm_pkg::PTM_MODE_CMP && !a_ev && !run_rise)
        |=> out_state == $past(out_state))
        else $error("compare pin moved without A flag");

    AST_TOGGLE: assert property (
        (ctrl.mode_select == ptm_pkg::PTM_MODE_CMP && a_ev && !run_rise &&
         ctrl.io_ctrl == ptm_pkg::IO_TOGGLE) |=> out_state != $past(out_state))
        else $error("toggle did not toggle");

    AST_RUN_INIT: assert property (
        run_rise |=> out_state == $past(ctrl.out_init))
        else $error("run rise did not load initial level");

    AST_FULL_DUTY: assert property (
        (ctrl.mode_select == ptm_pkg::PTM_MODE_PWM && ctrl.io_ctrl == ptm_pkg::IO_HIGH &&
         cmp.compare_p_value != 10'h000 && cmp.compare_a_value >= cmp.compare_p_value &&
         cnt < cmp.compare_p_value)
        |=> timer_out == ($past(ctrl.out_init) ^ $past(ctrl.out_invert)))
        else $error("duty at or above period not full");

    AST_PULSE_END: assert property (
        (single && a_ev && !ext_rise) |=> !run_bit ##1 !timer_out_oe || timer_out ==
         (~ctrl.out_init ^ ctrl.out_invert))
        else $error("A match did not end single pulse");

    AST_CAPTURE: assert property (
        cap_ev |=> cmp.compare_a_value == $past(cnt) && match_a_flag)
        else $error("capture did not latch counter");

    AST_CAP_OFF: assert property (
        (ctrl.mode_select == ptm_pkg::PTM_MODE_CAP && ctrl.io_ctrl == 2'h3) |-> !cap_ev)
        else $error("capture with edges disabled");

    AST_HOLD: assert property (
        (!run_bit || !timer_tick) && !(single && run_rise) |=> cnt == $past(cnt))
        else $error("counter moved while stopped");

    COV_CMP_TOGGLE: cover property (
        ctrl.mode_select == ptm_pkg::PTM_MODE_CMP && a_ev ##1 out_state != $past(out_state));
    COV_PWM_WRAP: cover property (ctrl.mode_select == ptm_pkg::PTM_MODE_PWM && p_ev);
    COV_SINGLE: cover property (single && ext_rise ##[1:20] single && a_ev);
    COV_CAPTURE: cover property (cap_ev ##[1:50] cap_ev);

endmodule // ptm_timer

// *** bench/ptm_far_side.sv ***
// far side model: capture and trigger pins, and the timer output wire
`timescale 1ns/1ns

module ptm_far_side (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic cap_cmd,
    input  wire logic ext_cmd,
    input  wire logic timer_out,
    input  wire logic timer_out_oe,
    output logic      capture_input_pin,
    output logic      external_clock_pin,
    output logic      pin_level
);

    logic last_level;

    ////////////////////////////////////////////////////////////////////////////////
    // pins move just after the edge, so the timer always sees settled levels
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_input_pin  <= 1'b0;
            external_clock_pin <= 1'b0;
        end else begin
            capture_input_pin  <= cap_cmd;
            external_clock_pin <= ext_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // no pull on the wire: a released pin shows the inverse of its last level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_level <= 1'b0;
        end else if (timer_out_oe) begin
            last_level <= timer_out;
        end
    end

    assign pin_level = timer_out_oe ? timer_out : ~last_level;

endmodule // ptm_far_side

// *** bench/tb_ptm_timer.sv ***
// self-checking bench of the periodic timer modes
`timescale 1ns/1ns

module tb_ptm_timer;

    logic                       sys_clk    = 1'b0;
    logic                       rst_n      = 1'b0;
    logic [ptm_pkg::PTM_AW-1:0] reg_addr   = 3'h0;
    logic [ptm_pkg::PTM_DW-1:0] reg_wdata  = 16'h0000;
    logic                       reg_wr     = 1'b0;
    logic                       reg_rd     = 1'b0;
    logic                       timer_tick = 1'b0;
    logic                       cap_cmd    = 1'b0;
    logic                       ext_cmd    = 1'b0;
    logic [ptm_pkg::PTM_DW-1:0] reg_rdata;
    logic                       capture_input_pin;
    logic                       external_clock_pin;
    logic                       timer_out;
    logic                       timer_out_oe;
    logic                       match_a_flag;
    logic                       match_p_flag;
    logic                       pin_level;
    logic [15:0]                rdat;
    int                         mismatches = 0;
    int                         checked    = 0;
    int                         highs;

    ptm_timer i_ptm_timer (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_tick(timer_tick), .capture_input_pin(capture_input_pin),
        .external_clock_pin(external_clock_pin), .timer_out(timer_out),
        .timer_out_oe(timer_out_oe), .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

    ptm_far_side i_ptm_far_side (.sys_clk(sys_clk), .rst_n(rst_n), .cap_cmd(cap_cmd),
        .ext_cmd(ext_cmd), .timer_out(timer_out), .timer_out_oe(timer_out_oe),
        .capture_input_pin(capture_input_pin), .external_clock_pin(external_clock_pin),
        .pin_level(pin_level));

    always #10 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [ptm_pkg::PTM_AW-1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample mid-cycle there
    task automatic rd_chk(input logic [ptm_pkg::PTM_AW-1:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        rdat = reg_rdata;
        chk(rdat, e);
    endtask

    task automatic ticks(input int n);
        @(posedge sys_clk);
        timer_tick <= 1'b1;
        repeat (n) @(posedge sys_clk);
        timer_tick <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    // pins move one edge after the request; a capture lands two edges later
    task automatic pins(input logic c, input logic e);
        @(posedge sys_clk);
        cap_cmd <= c;
        ext_cmd <= e;
        repeat (3) @(posedge sys_clk);
    endtask

    function automatic logic [15:0] ctl(input logic [1:0] m, input logic [1:0] io,
                                        input logic oc, input logic inv, input logic src,
                                        input logic clr);
        return {8'h00, m, io, oc, inv, src, clr};
    endfunction

    // pin high count over whole periods does not depend on the counter phase
    task automatic pwm_case(input logic [15:0] c, input logic [15:0] a, input logic [15:0] p,
                            input int n, input int exp);
        wr(ptm_pkg::ADDR_CMPP, p);
        wr(ptm_pkg::ADDR_CMPA, a);
        wr(ptm_pkg::ADDR_CTRL, c);
        repeat (8) @(posedge sys_clk);
        highs = 0;
        repeat (n) begin
            @(negedge sys_clk);
            highs += (pin_level === 1'b1) ? 1 : 0;
        end
        chk(16'(highs), 16'(exp));
    endtask

    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #200000;
        mismatches++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 8; a++) rd_chk(3'(a), 16'h0000);
        wr(ptm_pkg::ADDR_COUNT, 16'h0005);
        rd_chk(ptm_pkg::ADDR_COUNT, 16'h0000);
        wr(ptm_pkg::ADDR_CMPA, 16'h0002);
        wr(ptm_pkg::ADDR_CMPP, 16'h0003);
        for (int io = 0; io < 4; io++) begin
            wr(ptm_pkg::ADDR_RUN, 16'h0000);
            wr(ptm_pkg::ADDR_CTRL, ctl(ptm_pkg::PTM_MODE_CMP, 2'(io), io == 1, 0, 0, 0));
            wr(ptm_pkg::ADDR_STATUS, 16'h0003);
            wr(ptm_pkg::ADDR_RUN, 16'h0001);
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            chk(16'(pin_level), 16'(io == 1));
            chk(16'(timer_out_oe), 16'h0001);
            ticks(2);
            rd_chk(ptm_pkg::ADDR_STATUS, 16'h0001);
            chk(16'(pin_level), 16'(io >= 2));
            ticks(1);
            rd_chk(ptm_pkg::ADDR_STATUS, 16'h0003);
            chk(16'({match_p_flag, match_a_flag}), 16'h0003);
            chk(16'(pin_level), 16'(io >= 2));
        end
        wr(ptm_pkg::ADDR_RUN, 16'h0000);
        ticks(3);
        rd_chk(ptm_pkg::ADDR_COUNT, 16'h0000);
        wr(ptm_pkg::ADDR_CMPP, 16'h0001);
        wr(ptm_pkg::ADDR_CTRL, ctl(ptm_pkg::PTM_MODE_CMP, 0, 0, 0, 0, 1));
        wr(ptm_pkg::ADDR_STATUS, 16'h0003);
        wr(ptm_pkg::ADDR_RUN, 16'h0001);
        ticks(2);
        rd_chk(ptm_pkg::ADDR_COUNT, 16'h0000);
        rd_chk(ptm_pkg::ADDR_STATUS, 16'h0001);
        wr(ptm_pkg::ADDR_CMPA, 16'h0000);
        wr(ptm_pkg::ADDR_CTRL, ctl(ptm_pkg::PTM_MODE_TMR, 3, 1, 1, 0, 1));
        wr(ptm_pkg::ADDR_STATUS, 16'h0003);
        ticks(1023);
        rd_chk(ptm_pkg::ADDR_COUNT, 16'h03ff);
        ticks(1);
        rd_chk(ptm_pkg::ADDR_COUNT, 16'h0000);
        rd_chk(ptm_pkg::ADDR_STATUS, 16'h0000);
        chk(16'(timer_out_oe), 16'h0000);
        // capture: counter parked by holding the tick low
        wr(ptm_pkg::ADDR_CMPP, 16'h0000);
        wr(ptm_pkg::ADDR_CTRL, ctl(ptm_pkg::PTM_MODE_CAP, ptm_pkg::CAP_RISE, 0, 0, 0, 0));
        ticks(7);
        rd_chk(ptm_pkg::ADDR_COUNT, 16'h0007);
        pins(1'b1, 1'b0);
        rd_chk(ptm_pkg::ADDR_CMPA, 16'h0007);
        rd_chk(ptm_pkg::ADDR_STATUS, 16'h0001);
        wr(ptm_pkg::ADDR_CTRL, ctl(ptm_pkg::PTM_MODE_CAP, ptm_pkg::CAP_BOTH, 0, 0, 0, 0));
        ticks(2);
        pins(1'b0, 1'b0);
        rd_chk(ptm_pkg::ADDR_CMPA, 16'h0009);
        wr(ptm_pkg::ADDR_CTRL, ctl(ptm_pkg::PTM_MODE_CAP, 3, 0, 0, 0, 0));
        ticks(1);
        pins(1'b1, 1'b0);
        rd_chk(ptm_pkg::ADDR_CMPA, 16'h0009);
        rd_chk(ptm_pkg::ADDR_COUNT, 16'h000a);
        wr(ptm_pkg::ADDR_CTRL, ctl(ptm_pkg::PTM_MODE_CAP, ptm_pkg::CAP_FALL, 0, 0, 1, 0));
        // capture pin falls, clock pin rises: neither is an edge that counts here
        pins(1'b0, 1'b1);
        rd_chk(ptm_pkg::ADDR_CMPA, 16'h0009);
        pins(1'b0, 1'b0);
        rd_chk(ptm_pkg::ADDR_CMPA, 16'h000a);
        wr(ptm_pkg::ADDR_STATUS, 16'h0003);
        wr(ptm_pkg::ADDR_CMPP, 16'h000c);
        ticks(2);
        rd_chk(ptm_pkg::ADDR_COUNT, 16'h0000);
        rd_chk(ptm_pkg::ADDR_STATUS, 16'h0002);
        // pwm with the tick running every cycle
        @(posedge sys_clk);
        timer_tick <= 1'b1;
        pwm_case(ctl(ptm_pkg::PTM_MODE_PWM, 2, 1, 0, 0, 1), 1, 4, 40, 10);
        pwm_case(ctl(ptm_pkg::PTM_MODE_PWM, 2, 1, 1, 0, 0), 1, 4, 40, 30);
        pwm_case(ctl(ptm_pkg::PTM_MODE_PWM, 2, 1, 0, 0, 0), 4, 4, 40, 40);
        pwm_case(ctl(ptm_pkg::PTM_MODE_PWM, 2, 0, 0, 0, 0), 1, 4, 40, 30);
        wr(ptm_pkg::ADDR_STATUS, 16'h0003);
        pwm_case(ctl(ptm_pkg::PTM_MODE_PWM, 0, 1, 0, 0, 0), 1, 4, 40, 0);
        rd_chk(ptm_pkg::ADDR_STATUS, 16'h0003);
        pwm_case(ctl(ptm_pkg::PTM_MODE_PWM, 1, 1, 0, 0, 0), 1, 4, 40, 40);
        pwm_case(ctl(ptm_pkg::PTM_MODE_PWM, 2, 1, 0, 0, 0), 256, 0, 1024, 256);
        // single pulse: P value set low enough to clear the counter if it were used
        wr(ptm_pkg::ADDR_RUN, 16'h0000);
        wr(ptm_pkg::ADDR_CMPP, 16'h0002);
        wr(ptm_pkg::ADDR_CMPA, 16'h0005);
        wr(ptm_pkg::ADDR_CTRL, ctl(ptm_pkg::PTM_MODE_PWM, 3, 1, 0, 0, 0));
        wr(ptm_pkg::ADDR_STATUS, 16'h0003);
        ext_cmd <= 1'b1;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(16'(pin_level), 16'h0001);
        repeat (6) @(posedge sys_clk);
        rd_chk(ptm_pkg::ADDR_RUN, 16'h0000);
        rd_chk(ptm_pkg::ADDR_STATUS, 16'h0001);
        chk(16'(pin_level), 16'h0000);
        @(posedge sys_clk);
        timer_tick <= 1'b0;
        wr(ptm_pkg::ADDR_RUN, 16'h0001);
        rd_chk(ptm_pkg::ADDR_COUNT, 16'h0000);
        end_sim();
    end

endmodule // tb_ptm_timer
